// [atc_asserts.sv]
/* Checker for the trigger block: APB handshake and command strobes.
   Assumes it is bound to the block's top module. */
`include "atc_regs.vh"
module atc_asserts
(
    // Clock and reset
    input wire        CLOCK_IN,
    input wire        SYS_RST_IN,
    // APB
    input wire        PSEL_IN,
    input wire        PENABLE_IN,
    input wire        PWRITE_IN,
    input wire [7:0]  PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire [31:0] PRDATA_OUT,
    input wire        PREADY_OUT,
    input wire        PSLVERR_OUT,
    // Acquisition outputs
    input wire        ACQ_ENABLE_OUT,
    input wire        FIFO_CLEAR_OUT,
    input wire        CTAB_RESET_OUT,
    input wire        FREEZE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    wire setup = PSEL_IN && !PENABLE_IN;
    wire acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire cmd_wr = acc && PWRITE_IN && (PADDR_IN == `ATC_COMMAND_OFS);

    a_ready_next: assert property (setup |=> PREADY_OUT)
        else $error("no ready after setup");
    a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property
        (setup && (PADDR_IN > 8'h0C || PADDR_IN[1:0] != 2'b00) |=> PSLVERR_OUT)
        else $error("no error on unmapped address");
    a_cmd_reads_zero: assert property
        (acc && !PWRITE_IN && PADDR_IN == `ATC_COMMAND_OFS |-> PRDATA_OUT == 32'h0000_0000)
        else $error("command register read not zero");
    a_fifo_on_cmd: assert property (cmd_wr && PWDATA_IN[4] |-> ##[1:2] FIFO_CLEAR_OUT)
        else $error("no fifo clear after command");
    a_fifo_pulse: assert property (FIFO_CLEAR_OUT |=> !FIFO_CLEAR_OUT)
        else $error("fifo clear longer than one cycle");
    a_freeze_cleared: assert property (FIFO_CLEAR_OUT |-> ##[0:1] !FREEZE_OUT)
        else $error("freeze kept over fifo clear");
    a_ctab_on_cmd: assert property
        (cmd_wr && PWDATA_IN[5] |-> ##[1:2] CTAB_RESET_OUT ##1 !CTAB_RESET_OUT)
        else $error("no table reset pulse after command");
    a_freeze_on_cmd: assert property
        (cmd_wr && PWDATA_IN[2] && !PWDATA_IN[4] |-> ##[1:2] FREEZE_OUT)
        else $error("freeze not immediate");
    a_abort_idle: assert property (cmd_wr && PWDATA_IN[3] |-> ##[1:2] !ACQ_ENABLE_OUT)
        else $error("abort not immediate");
    cover property (cmd_wr && PWDATA_IN[0]);
    cover property ($rose(ACQ_ENABLE_OUT));
    cover property (PSLVERR_OUT);
endmodule

bind atc_trigger_ctrl atc_asserts u_chk
(
    .CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .ACQ_ENABLE_OUT(ACQ_ENABLE_OUT),
    .FIFO_CLEAR_OUT(FIFO_CLEAR_OUT), .CTAB_RESET_OUT(CTAB_RESET_OUT),
    .FREEZE_OUT(FREEZE_OUT)
);

// [atc_partner.sv]
/* Far side model: free-running camera, trigger pins and encoder pins.
   Assumes the bench calls drive just after a clock edge. */
module atc_partner
#(
    parameter int FRAME_GAP = 40
)
(
    // Clock
    input  wire logic clk_in,
    // Pins toward the block
    output logic      trig_a_out,
    output logic      trig_b_out,
    output logic      enc_a_out,
    output logic      enc_b_out,
    output logic      frame_start_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q = 0;
    initial {enc_a_out, trig_b_out, trig_a_out} <= 3'b000;
    // Camera timing free runs, never restarted by triggers
    always @(posedge clk_in)
    begin
        cnt_q           <= (cnt_q == FRAME_GAP - 1) ? 0 : cnt_q + 1;
        frame_start_out <= (cnt_q < 4);
        enc_b_out       <= cnt_q[0];
    end
    // Trigger and encoder A levels
    task automatic drive(input logic [2:0] pins);
        @(posedge clk_in);
        {enc_a_out, trig_b_out, trig_a_out} <= pins;
    endtask
endmodule

// [atc_regs.vh]
/*
 * Register offsets, field positions, codes and timing counts of the
 * acquisition trigger control block.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef ATC_REGS_VH
`define ATC_REGS_VH

// Byte offsets
`define ATC_FRAME_CFG_OFS       8'h00
`define ATC_LINE_CFG_OFS        8'h04
`define ATC_COMMAND_OFS         8'h08
`define ATC_STATUS_OFS          8'h0C
`define ATC_ADDR_W              8

// Frame configuration fields
`define ATC_FMODE_LSB           0
`define ATC_FMODE_MSB           2
`define ATC_FPOL_BIT            4
`define ATC_EXT_ATTACH_BIT      8

// Frame mode codes
`define ATC_FRAME_FREE_RUNNING  3'h0
`define ATC_ARMED_COMMAND       3'h1
`define ATC_ARMED_START_STOP    3'h2
`define ATC_FRAME_SINGLE_SHOT   3'h3
`define ATC_FRAME_SS_INTERNAL   3'h4
`define ATC_CONTINUOUS_SOURCE   3'h5
`define ATC_WINDOW_A_START_B    3'h6
`define ATC_WINDOW_A_LEVEL      3'h7

// Line configuration fields and codes
`define ATC_LMODE_LSB           0
`define ATC_LMODE_MSB           1
`define ATC_LPOL_BIT            4
`define ATC_ESEL_LSB            8
`define ATC_ESEL_MSB            9
`define ATC_LINE_FREE_RUNNING   2'h0
`define ATC_LINE_SINGLE_SHOT    2'h1
`define ATC_LINE_SS_INTERNAL    2'h2
`define ATC_FIRST_ENCODER       2'h0
`define ATC_ENCODER_UNKNOWN     2'h3

// Command bits
`define ATC_CMD_SNAP_BIT        0
`define ATC_CMD_GRAB_BIT        1
`define ATC_CMD_FREEZE_BIT      2
`define ATC_CMD_ABORT_BIT       3
`define ATC_CMD_FIFO_RST_BIT    4
`define ATC_CMD_CTAB_RST_BIT    5
`define ATC_CMD_SW_TRIG_A_BIT   6
`define ATC_CMD_SW_TRIG_B_BIT   7

// Status bits
`define ATC_ST_PENDING_BIT      0
`define ATC_ST_ACQUIRING_BIT    1
`define ATC_ST_GRAB_BIT         2
`define ATC_ST_FREEZE_BIT       3
`define ATC_ST_EXT_BIT          4

// Timing counts
`define ATC_SELF_TRIG_PERIOD    16'h0FFF
`define ATC_LINE_SELF_PERIOD    16'h003F

`endif

// [atc_tb.sv]
/* Bench for the trigger block: APB host tasks, one task per scenario.
   Assumes the partner model drives the trigger and camera pins. */
`include "atc_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 40;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  padr;
    logic [31:0] pwd;
    wire  [31:0] prd;
    wire         prdy, perr, ta, trb, ea, eb, fs, acq, lcap, frz, fclr, ctab;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          fcl_n = 0;
    int          ctb_n = 0;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Pulse counters, sampled mid cycle
    always @(negedge clk)
    begin
        fcl_n += (fclr === 1'b1);
        ctb_n += (ctab === 1'b1);
    end

    atc_trigger_ctrl DUT
    (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .TRIG_A_IN(ta), .TRIG_B_IN(trb),
        .ENC_A_IN(ea), .ENC_B_IN(eb), .CAM_FRAME_START_IN(fs),
        .ACQ_ENABLE_OUT(acq), .LINE_CAPTURE_OUT(lcap), .FIFO_CLEAR_OUT(fclr),
        .CTAB_RESET_OUT(ctab), .FREEZE_OUT(frz)
    );
    atc_partner #(.FRAME_GAP(GAP)) u_cam
    (
        .clk_in(clk), .trig_a_out(ta), .trig_b_out(trb), .enc_a_out(ea),
        .enc_b_out(eb), .frame_start_out(fs)
    );

    task automatic test_done;
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask
    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (prdy !== 1'b1 && n < 20);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (n >= 20)
        begin
            bad_count++;
            test_done();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check("prdata", r, x);
        check("pslverr", {31'b0, e}, {31'b0, xe});
    endtask
    task automatic wait_acq(input logic v, input int lim);
        int n;
        n = 0;
        while (acq !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        check("acq_enable", {31'b0, acq}, {31'b0, v});
        if (acq !== v)
            test_done();
    endtask
    task automatic count_lines(input logic [2:0] pins, input int len, input int x);
        int c;
        c = 0;
        u_cam.drive(pins);
        repeat (len)
        begin
            @(posedge clk);
            c += (lcap === 1'b1);
        end
        check("line_pulses", c, x);
    endtask

    task automatic s_cmds;
        wr(`ATC_COMMAND_OFS, 32'h0000_0004);
        repeat (2) @(posedge clk);
        check("freeze", {31'b0, frz}, 32'h0000_0001);
        wr(`ATC_COMMAND_OFS, 32'h0000_0010);
        repeat (2) @(posedge clk);
        check("freeze", {31'b0, frz}, 32'h0000_0000);
        check("fifo_clear", fcl_n, 1);
        wr(`ATC_COMMAND_OFS, 32'h0000_0020);
        rd(`ATC_COMMAND_OFS, 32'h0000_0000, 1'b0);
        check("ctab_reset", ctb_n, 1);
    endtask
    task automatic s_regs;
        rd(8'h10, 32'h0000_0000, 1'b1);
        rd(8'h02, 32'h0000_0000, 1'b1);
        for (int m = 0; m < 8; m++)
        begin
            wr(`ATC_FRAME_CFG_OFS, {27'b0, m[0], 1'b0, m[2:0]});
            rd(`ATC_FRAME_CFG_OFS, {27'b0, m[0], 1'b0, m[2:0]}, 1'b0);
        end
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0002);
        rd(`ATC_LINE_CFG_OFS, 32'h0000_0002, 1'b0);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0011);
        rd(`ATC_LINE_CFG_OFS, 32'h0000_0011, 1'b0);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0013);
        rd(`ATC_LINE_CFG_OFS, 32'h0000_0011, 1'b0);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0311);
        rd(`ATC_LINE_CFG_OFS, 32'h0000_0011, 1'b0);
    endtask
    task automatic s_armed;
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0001);
        wr(`ATC_COMMAND_OFS, 32'h0000_0008);
        wait_acq(1'b0, 3);
        wr(`ATC_COMMAND_OFS, 32'h0000_0001);
        u_cam.drive(3'b001);
        repeat (2 * GAP) @(posedge clk);
        check("acq_enable", {31'b0, acq}, 32'h0000_0000);
        rd(`ATC_STATUS_OFS, 32'h0000_0001, 1'b0);
        wr(`ATC_COMMAND_OFS, 32'h0000_0040);
        wait_acq(1'b1, 2 * GAP);
        wait_acq(1'b0, 2 * GAP);
        repeat (2 * GAP) @(posedge clk);
        check("acq_enable", {31'b0, acq}, 32'h0000_0000);
        u_cam.drive(3'b000);
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0101);
        rd(`ATC_FRAME_CFG_OFS, 32'h0000_0101, 1'b0);
        wr(`ATC_COMMAND_OFS, 32'h0000_0001);
        u_cam.drive(3'b001);
        wait_acq(1'b1, 2 * GAP);
        wait_acq(1'b0, 2 * GAP);
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0111);
        wr(`ATC_COMMAND_OFS, 32'h0000_0001);
        u_cam.drive(3'b000);
        wait_acq(1'b1, 2 * GAP);
        wait_acq(1'b0, 2 * GAP);
    endtask
    task automatic s_window;
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0106);
        u_cam.drive(3'b001);
        wait_acq(1'b1, 2 * GAP);
        u_cam.drive(3'b011);
        wait_acq(1'b0, 2 * GAP);
        u_cam.drive(3'b000);
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0107);
        u_cam.drive(3'b001);
        wait_acq(1'b1, 2 * GAP);
        u_cam.drive(3'b000);
        wait_acq(1'b0, 2 * GAP);
    endtask
    task automatic s_line;
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0000);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0000);
        wait_acq(1'b1, 3 * GAP);
        count_lines(3'b000, 30, 30);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0001);
        count_lines(3'b100, 30, 1);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0011);
        count_lines(3'b000, 30, 1);
        count_lines(3'b100, 30, 0);
        wr(`ATC_LINE_CFG_OFS, 32'h0000_0002);
        count_lines(3'b000, 128, 2);
    endtask
    task automatic s_self;
        wr(`ATC_FRAME_CFG_OFS, 32'h0000_0004);
        wr(`ATC_COMMAND_OFS, 32'h0000_0008);
        wr(`ATC_COMMAND_OFS, 32'h0000_0001);
        wait_acq(1'b1, 4200);
        wait_acq(1'b0, 2 * GAP);
    endtask

    initial
    begin
        rst  <= 1'b1;
        psel <= 1'b0;
        pen  <= 1'b0;
        pwr  <= 1'b0;
        padr <= 8'h00;
        pwd  <= 32'h0000_0000;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wait_acq(1'b1, 3 * GAP);
        s_cmds();
        s_regs();
        s_armed();
        s_window();
        s_line();
        s_self();
        test_done();
    end
endmodule

// [atc_trigger_ctrl.v]
/*
 * Frame and line trigger control with APB register access, acquire
 * command arming, start/stop windows, FIFO and control table resets.
 * Assumes one 40 MHz clock, trigger and encoder pins asynchronous to it,
 * camera frame start pin asynchronous as well.
 */
//
// Behaviour
// RULE1: FIFO reset command clears data FIFO and the freeze register.
// RULE2: Control table reset command restores table contents to reset values.
// RULE3: Frame free run acquires continuously with no trigger.
// RULE4: Frame trigger edge is rising or falling by polarity setting.
// RULE5: Armed mode holds snap or grab pending until a frame trigger.
// RULE6: Latched command starts capture at the next camera frame start.
// RULE7: Freeze and abort act at once; only snap and grab are gated.
// RULE8: Start/stop modes make start and stop from triggers themselves.
// RULE9: A-start/B-stop window starts on A rising, stops on B rising.
// RULE10: A-start/A-stop window starts on A rising, stops on A falling.
// RULE11: Self-triggered frame single shot makes triggers internally.
// RULE12: Armed mode never resets camera timing; latency up to one frame.
// RULE13: Each accepted frame trigger captures one whole frame.
// RULE14: Software triggers always act; external only while attached.
// RULE15: Line single shot needs one trigger per line; free run needs none.
// RULE16: One line polarity picks rising or falling for all line triggers.
// RULE17: Self-triggered line single shot makes line triggers internally.
// RULE18: First encoder selected uses encoder A and ignores encoder B.
// RULE19: Host reads back frame trigger mode and polarity.
// RULE20: Line readback gives mode, polarity, select, or unknown code.
// RULE21: Host writes the acquire command before the trigger arrives.
// RULE22: Attach control gates external trigger, other settings unchanged.
// RULE23: External trigger and encoder pins are synchronised then edge detected.
// RULE24: Unsupported mode, polarity or encoder code leaves settings unchanged.
`include "atc_regs.vh"

module atc_trigger_ctrl
(
    // Clock and reset
    input  wire        CLOCK_IN,
    input  wire        SYS_RST_IN,
    // APB slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    // Trigger, encoder and camera pins
    input  wire        TRIG_A_IN,
    input  wire        TRIG_B_IN,
    input  wire        ENC_A_IN,
    input  wire        ENC_B_IN,
    input  wire        CAM_FRAME_START_IN,
    // Acquisition control outputs
    output reg         ACQ_ENABLE_OUT,
    output reg         LINE_CAPTURE_OUT,
    output reg         FIFO_CLEAR_OUT,
    output reg         CTAB_RESET_OUT,
    output reg         FREEZE_OUT
);

    // Acquisition states
    localparam [3:0] ST_IDLE    = 4'b0001;
    localparam [3:0] ST_PENDING = 4'b0010;
    localparam [3:0] ST_WAIT_FR = 4'b0100;
    localparam [3:0] ST_CAPTURE = 4'b1000;

    reg  [2:0]  fmode_q;
    reg         fpol_q;
    reg         ext_attach_q;
    reg  [1:0]  lmode_q;
    reg         lpol_q;
    reg  [1:0]  esel_q;
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg         grab_q;
    reg         grab_d;
    reg  [2:0]  ta_sync_q;
    reg  [2:0]  tb_sync_q;
    reg  [2:0]  ea_sync_q;
    reg  [2:0]  fs_sync_q;
    reg         sw_a_q;
    reg         sw_b_q;
    reg  [15:0] fself_cnt_q;
    reg  [15:0] lself_cnt_q;
    reg         fself_q;
    reg         lself_q;

    wire        wr_acc;
    wire        rd_acc;
    wire        cmd_wr;
    wire        ext_a_rise;
    wire        ext_a_fall;
    wire        ext_b_rise;
    wire        a_rise;
    wire        a_fall;
    wire        b_rise;
    wire        frame_trig;
    wire        frame_start;
    wire        line_edge;
    wire        snap_cmd;
    wire        grab_cmd;
    wire        abort_cmd;
    wire        start_stop;
    wire        win_start;
    wire        win_stop;
    wire [2:0]  new_fmode;
    wire [1:0]  new_lmode;
    wire [1:0]  new_esel;
    reg  [31:0] rd_mux;

    assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
    assign rd_acc = PSEL_IN & PENABLE_IN & ~PWRITE_IN & PREADY_OUT;
    assign cmd_wr = wr_acc & (PADDR_IN == `ATC_COMMAND_OFS);

    // Pin synchronisers; stage 0 feeds only stage 1
    always @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            ta_sync_q <= 3'h0;
            tb_sync_q <= 3'h0;
            ea_sync_q <= 3'h0;
            fs_sync_q <= 3'h0;
        end
        else
        begin
            ta_sync_q <= {ta_sync_q[1:0], TRIG_A_IN};           // see RULE23
            tb_sync_q <= {tb_sync_q[1:0], TRIG_B_IN};           // see RULE23
            ea_sync_q <= {ea_sync_q[1:0], ENC_A_IN};            // see RULE18
            fs_sync_q <= {fs_sync_q[1:0], CAM_FRAME_START_IN};
        end
    end

    // Encoder B is never sampled
    wire unused_enc_b = ENC_B_IN;                               // see RULE18

    // Edge detect on synchronised stages 1 and 2
    assign ext_a_rise = ext_attach_q & ta_sync_q[1] & ~ta_sync_q[2];   // see RULE22
    assign ext_a_fall = ext_attach_q & ~ta_sync_q[1] & ta_sync_q[2];
    assign ext_b_rise = ext_attach_q & tb_sync_q[1] & ~tb_sync_q[2];
    assign a_rise = ext_a_rise | sw_a_q;                        // see RULE14
    assign a_fall = ext_a_fall;
    assign b_rise = ext_b_rise | sw_b_q;                        // see RULE14
    assign frame_trig = (fmode_q == `ATC_FRAME_SS_INTERNAL) ? fself_q
                      : (fpol_q ? (ext_a_fall | sw_a_q) : a_rise);   // see RULE4
    assign frame_start = fs_sync_q[1] & ~fs_sync_q[2];
    assign line_edge = lpol_q ? (~ea_sync_q[1] & ea_sync_q[2])
                              : (ea_sync_q[1] & ~ea_sync_q[2]);      // see RULE16

    assign snap_cmd  = cmd_wr & PWDATA_IN[`ATC_CMD_SNAP_BIT];
    assign grab_cmd  = cmd_wr & PWDATA_IN[`ATC_CMD_GRAB_BIT];
    assign abort_cmd = cmd_wr & PWDATA_IN[`ATC_CMD_ABORT_BIT];
    assign start_stop = (fmode_q == `ATC_ARMED_START_STOP) |
                        (fmode_q == `ATC_WINDOW_A_START_B) |
                        (fmode_q == `ATC_WINDOW_A_LEVEL);
    assign win_start = a_rise;                                  // see RULE9
    assign win_stop  = (fmode_q == `ATC_WINDOW_A_LEVEL) ? a_fall : b_rise;  // see RULE10

    assign new_fmode = PWDATA_IN[`ATC_FMODE_MSB:`ATC_FMODE_LSB];
    assign new_lmode = PWDATA_IN[`ATC_LMODE_MSB:`ATC_LMODE_LSB];
    assign new_esel  = PWDATA_IN[`ATC_ESEL_MSB:`ATC_ESEL_LSB];

    // Configuration registers
    always @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            fmode_q      <= `ATC_FRAME_FREE_RUNNING;
            fpol_q       <= 1'b0;
            ext_attach_q <= 1'b0;
            lmode_q      <= `ATC_LINE_FREE_RUNNING;
            lpol_q       <= 1'b0;
            esel_q       <= `ATC_FIRST_ENCODER;
            sw_a_q       <= 1'b0;
            sw_b_q       <= 1'b0;
        end
        else
        begin
            sw_a_q <= cmd_wr & PWDATA_IN[`ATC_CMD_SW_TRIG_A_BIT];
            sw_b_q <= cmd_wr & PWDATA_IN[`ATC_CMD_SW_TRIG_B_BIT];
            if (wr_acc && PADDR_IN == `ATC_FRAME_CFG_OFS)
            begin
                fmode_q      <= new_fmode;                      // All eight codes defined
                fpol_q       <= PWDATA_IN[`ATC_FPOL_BIT];
                ext_attach_q <= PWDATA_IN[`ATC_EXT_ATTACH_BIT]; // see RULE22
            end
            if (wr_acc && PADDR_IN == `ATC_LINE_CFG_OFS &&
                new_lmode != 2'h3 && new_esel == `ATC_FIRST_ENCODER)
            begin
                lmode_q <= new_lmode;                           // see RULE24
                lpol_q  <= PWDATA_IN[`ATC_LPOL_BIT];
                esel_q  <= new_esel;
            end
        end
    end

    // Acquisition sequencer
    always @*
    begin
        state_d = state_q;
        grab_d  = grab_q;
        case (state_q)
            ST_IDLE:
            begin
                if (fmode_q == `ATC_FRAME_FREE_RUNNING ||
                    fmode_q == `ATC_CONTINUOUS_SOURCE)
                begin
                    state_d = ST_WAIT_FR;                       // see RULE3
                    grab_d  = 1'b1;
                end
                else if (start_stop)
                begin
                    if (win_start)
                    begin
                        state_d = ST_WAIT_FR;                   // see RULE8
                        grab_d  = 1'b1;
                    end
                end
                else if (snap_cmd | grab_cmd)
                begin
                    state_d = ST_PENDING;                       // see RULE5
                    grab_d  = grab_cmd;
                end
            end
            ST_PENDING:
            begin
                if (frame_trig)
                    state_d = ST_WAIT_FR;                       // see RULE12
            end
            ST_WAIT_FR:
            begin
                if (frame_start)
                    state_d = ST_CAPTURE;                       // see RULE6
            end
            ST_CAPTURE:
            begin
                if (frame_start && !grab_q)
                    state_d = ST_IDLE;                          // see RULE13
                else if (frame_start && !start_stop &&
                         fmode_q != `ATC_FRAME_FREE_RUNNING &&
                         fmode_q != `ATC_CONTINUOUS_SOURCE)
                    state_d = ST_PENDING;                       // see RULE13
            end
            default:
                state_d = ST_IDLE;
        endcase
        if (start_stop && win_stop && state_q != ST_IDLE)
        begin
            state_d = ST_IDLE;                                  // see RULE8
        end
        if (cmd_wr && PWDATA_IN[`ATC_CMD_FREEZE_BIT])
        begin
            grab_d = 1'b0;                                      // see RULE7
        end
        if (abort_cmd)
        begin
            state_d = ST_IDLE;                                  // see RULE7
        end
    end

    // Self trigger timers
    always @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            fself_cnt_q <= 16'h0000;
            lself_cnt_q <= 16'h0000;
            fself_q     <= 1'b0;
            lself_q     <= 1'b0;
        end
        else
        begin
            fself_q <= (fself_cnt_q == `ATC_SELF_TRIG_PERIOD);  // see RULE11
            fself_cnt_q <= (fself_cnt_q == `ATC_SELF_TRIG_PERIOD) ? 16'h0000
                         : fself_cnt_q + 16'h0001;
            lself_q <= (lself_cnt_q == `ATC_LINE_SELF_PERIOD);  // see RULE17
            lself_cnt_q <= (lself_cnt_q == `ATC_LINE_SELF_PERIOD) ? 16'h0000
                         : lself_cnt_q + 16'h0001;
        end
    end

    // State, outputs and APB answer
    always @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            state_q          <= ST_IDLE;
            grab_q           <= 1'b0;
            ACQ_ENABLE_OUT   <= 1'b0;
            LINE_CAPTURE_OUT <= 1'b0;
            FIFO_CLEAR_OUT   <= 1'b0;
            CTAB_RESET_OUT   <= 1'b0;
            FREEZE_OUT       <= 1'b0;
            PRDATA_OUT       <= 32'h0000_0000;
            PREADY_OUT       <= 1'b0;
            PSLVERR_OUT      <= 1'b0;
        end
        else
        begin
            state_q        <= state_d;
            grab_q         <= grab_d;
            ACQ_ENABLE_OUT <= (state_d == ST_CAPTURE);
            case (lmode_q)
                `ATC_LINE_SINGLE_SHOT:
                begin
                    LINE_CAPTURE_OUT <= line_edge & (state_q == ST_CAPTURE);  // see RULE15
                end
                `ATC_LINE_SS_INTERNAL:
                begin
                    LINE_CAPTURE_OUT <= lself_q & (state_q == ST_CAPTURE);    // see RULE17
                end
                default:
                begin
                    LINE_CAPTURE_OUT <= (state_q == ST_CAPTURE);              // see RULE15
                end
            endcase
            FIFO_CLEAR_OUT <= cmd_wr & PWDATA_IN[`ATC_CMD_FIFO_RST_BIT];     // see RULE1
            CTAB_RESET_OUT <= cmd_wr & PWDATA_IN[`ATC_CMD_CTAB_RST_BIT];     // see RULE2
            if (cmd_wr && PWDATA_IN[`ATC_CMD_FIFO_RST_BIT])
            begin
                FREEZE_OUT <= 1'b0;                                          // see RULE1
            end
            else if (cmd_wr && PWDATA_IN[`ATC_CMD_FREEZE_BIT])
            begin
                FREEZE_OUT <= 1'b1;                                          // see RULE7
            end
            else if (snap_cmd | grab_cmd)
            begin
                FREEZE_OUT <= 1'b0;
            end
            PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & (PADDR_IN[1:0] != 2'b00 ||
                           PADDR_IN > `ATC_STATUS_OFS);
            if (rd_acc)
                PRDATA_OUT <= 32'h0000_0000;
            else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
                PRDATA_OUT <= rd_mux;
        end
    end

    // Read mux
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (PADDR_IN)
            `ATC_FRAME_CFG_OFS:
            begin
                rd_mux[`ATC_FMODE_MSB:`ATC_FMODE_LSB] = fmode_q;     // see RULE19
                rd_mux[`ATC_FPOL_BIT]       = fpol_q;
                rd_mux[`ATC_EXT_ATTACH_BIT] = ext_attach_q;
            end
            `ATC_LINE_CFG_OFS:
            begin
                rd_mux[`ATC_LMODE_MSB:`ATC_LMODE_LSB] = lmode_q;     // see RULE20
                rd_mux[`ATC_LPOL_BIT] = lpol_q;
                rd_mux[`ATC_ESEL_MSB:`ATC_ESEL_LSB] =
                    (esel_q == `ATC_FIRST_ENCODER) ? esel_q : `ATC_ENCODER_UNKNOWN;
            end
            `ATC_COMMAND_OFS:
                rd_mux = 32'h0000_0000;
            `ATC_STATUS_OFS:
            begin
                rd_mux[`ATC_ST_PENDING_BIT]   = (state_q == ST_PENDING);
                rd_mux[`ATC_ST_ACQUIRING_BIT] = (state_q == ST_CAPTURE);
                rd_mux[`ATC_ST_GRAB_BIT]      = grab_q;
                rd_mux[`ATC_ST_FREEZE_BIT]    = FREEZE_OUT;
                rd_mux[`ATC_ST_EXT_BIT]       = ext_attach_q;
            end
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

endmodule
